// >>> rtl/tbl_pkg.sv
package tbl_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 3;
  localparam int NUM_REGS = 4;

  // ****************************************
  // Register select, address bits [2:1]
  // ****************************************
  localparam logic [1:0] SEL_COUNT   = 2'h0;
  localparam logic [1:0] SEL_CMP_A   = 2'h1;
  localparam logic [1:0] SEL_CMP_B   = 2'h2;
  localparam logic [1:0] SEL_CAPTURE = 2'h3;

  // ****************************************
  // Byte select, address bit 0
  // ****************************************
  localparam int         ADDR_HI_BIT = 0;
  localparam logic       BYTE_LOWER  = 1'h0;
  localparam logic       BYTE_UPPER  = 1'h1;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  HOLD_RST  = 8'h00;
  localparam logic [7:0]  RDATA_RST = 8'h00;
  localparam logic [15:0] LOAD_RST  = 16'h0000;
  localparam logic [3:0]  STB_RST   = 4'h0;

endpackage

// >>> rtl/tbl_hold_if.sv
`timescale 1ns/1ns
interface tbl_hold_if;
  logic       load_en;
  logic [7:0] load_byte;
  logic [7:0] value;

  modport owner (input load_en, input load_byte, output value);
  modport user  (output load_en, output load_byte, input value);
endinterface

// >>> rtl/tbl_hold_reg.sv
`timescale 1ns/1ns
module tbl_hold_reg (
  // Clock and reset
  input wire logic     sys_clk,
  input wire logic     rst_sync_n,
  // Holding register port
  tbl_hold_if.owner    hold
);

  // ****************************************
  // Single shared upper-byte register
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      hold.value <= tbl_pkg::HOLD_RST;
    else if (hold.load_en)
      hold.value <= hold.load_byte;
  end

endmodule // tbl_hold_reg

// >>> rtl/tbl_timer16_access.sv
`timescale 1ns/1ns
module tbl_timer16_access (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // CPU byte bus
  input  wire logic [2:0]  cpu_addr,
  input  wire logic        cpu_rd,
  input  wire logic        cpu_wr,
  input  wire logic [7:0]  cpu_wdata,
  output logic      [7:0]  cpu_rdata,
  output logic             cpu_rvalid,
  // Timer live values
  input  wire logic [15:0] timer_count_value,
  input  wire logic [15:0] compare_value_a,
  input  wire logic [15:0] compare_value_b,
  input  wire logic [15:0] capture_value,
  // Timer load strobes
  output logic      [3:0]  load_strobe,
  output logic      [15:0] load_data
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (tbl_pkg::WORD_W != 2 * tbl_pkg::BYTE_W)
  begin : g_word_chk
    $error("word must hold exactly two bytes");
  end

  if (tbl_pkg::NUM_REGS != 4)
  begin : g_regs_chk
    $error("register select decodes four registers");
  end

  if (tbl_pkg::ADDR_W != 3)
  begin : g_addr_chk
    $error("address is select pair plus byte bit");
  end

  // ****************************************
  // Reset synchroniser
  // ****************************************
  logic rst_meta_reg;
  logic rst_sync_n;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_n   <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_n   <= rst_meta_reg;
    end
  end

  // ****************************************
  // Access decode
  // ****************************************
  tbl_hold_if hif ();

  logic [1:0]  reg_sel;
  logic        is_upper;
  logic        is_compare;
  logic        rd_take;
  logic [15:0] live_word;
  logic [7:0]  live_upper;
  logic [7:0]  rd_byte;

  assign reg_sel    = cpu_addr[2:1];
  assign is_upper   = cpu_addr[tbl_pkg::ADDR_HI_BIT];
  assign is_compare = (reg_sel == tbl_pkg::SEL_CMP_A) || (reg_sel == tbl_pkg::SEL_CMP_B);
  assign rd_take    = cpu_rd && !cpu_wr;

  always_comb
  begin
    unique case (reg_sel)
      tbl_pkg::SEL_COUNT: live_word = timer_count_value;
      tbl_pkg::SEL_CMP_A: live_word = compare_value_a;
      tbl_pkg::SEL_CMP_B: live_word = compare_value_b;
      tbl_pkg::SEL_CAPTURE: live_word = capture_value;
    endcase
  end

  assign live_upper = live_word[15:8];

  always_comb
  begin
    if (is_upper == tbl_pkg::BYTE_LOWER)
      rd_byte = live_word[7:0];
    else if (is_compare)
      rd_byte = live_upper;
    else
      rd_byte = hif.value;
  end

  // ****************************************
  // Holding register control
  // ****************************************
  assign hif.load_en   = (cpu_wr && is_upper)
                       || (rd_take && !is_upper && !is_compare);
  assign hif.load_byte = cpu_wr ? cpu_wdata : live_upper;

  tbl_hold_reg u_hold (
    .sys_clk    (sys_clk),
    .rst_sync_n (rst_sync_n),
    .hold       (hif)
  );

  // ****************************************
  // Read data path
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      cpu_rdata  <= tbl_pkg::RDATA_RST;
      cpu_rvalid <= 1'b0;
    end
    else
    begin
      cpu_rvalid <= rd_take;
      if (rd_take)
        cpu_rdata <= rd_byte;
    end
  end

  // ****************************************
  // Word load path
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      load_strobe <= tbl_pkg::STB_RST;
      load_data   <= tbl_pkg::LOAD_RST;
    end
    else
    begin
      load_strobe <= tbl_pkg::STB_RST;
      if (cpu_wr && !is_upper)
      begin
        load_strobe[reg_sel] <= 1'b1;
        load_data            <= {hif.value, cpu_wdata};
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_sync_n);

  AST_LOWER_WRITE_LOADS: assert property (
    cpu_wr && !is_upper |=> load_strobe == (4'h1 << $past(reg_sel))
      && load_data == {$past(hif.value), $past(cpu_wdata)})
    else $error("lower write did not load full word");

  AST_UPPER_WRITE_HOLDS: assert property (
    cpu_wr && is_upper |=> load_strobe == 4'h0 && hif.value == $past(cpu_wdata))
    else $error("upper write not held or loaded early");

  AST_LOWER_READ_SNAPSHOT: assert property (
    rd_take && !is_upper && !is_compare |=> cpu_rvalid
      && hif.value == $past(live_upper) && cpu_rdata == $past(live_word[7:0]))
    else $error("lower read did not snapshot upper byte");

  AST_COMPARE_BYPASS: assert property (
    rd_take && is_compare |=> $stable(hif.value)
      && ($past(is_upper) ? cpu_rdata == $past(live_upper) : 1'b1))
    else $error("compare read touched holding register");

  AST_UPPER_FROM_HOLD: assert property (
    rd_take && is_upper && !is_compare |=> cpu_rdata == $past(hif.value)
      && $stable(hif.value))
    else $error("upper read not from holding register");

  AST_HOLD_CAUSE: assert property (
    !(cpu_wr && is_upper) && !(rd_take && !is_upper && !is_compare) |=> $stable(hif.value))
    else $error("holding register changed without cause");

  AST_WRITE_WINS: assert property (
    cpu_wr && cpu_rd |=> !cpu_rvalid)
    else $error("read taken beside a write");

  AST_RVALID_ONLY_ON_READ: assert property (
    !rd_take |=> !cpu_rvalid)
    else $error("read answer without a read");

  AST_RDATA_STANDS: assert property (
    !rd_take |=> $stable(cpu_rdata))
    else $error("read data changed without a read");

  AST_LOWER_READ_ANSWER: assert property (
    rd_take && !is_upper |=> cpu_rvalid && cpu_rdata == $past(live_word[7:0]))
    else $error("lower byte read returned wrong byte");

  AST_STROBE_ONLY_ON_LOWER: assert property (
    !(cpu_wr && !is_upper) |=> load_strobe == 4'h0)
    else $error("load strobe without lower write");

  AST_LOAD_DATA_STANDS: assert property (
    !(cpu_wr && !is_upper) |=> $stable(load_data))
    else $error("load word changed without lower write");

  AST_STROBE_ONE_HOT: assert property (
    $onehot0(load_strobe))
    else $error("more than one register loaded");

  COV_WORD_WRITE: cover property (
    cpu_wr && is_upper ##1 cpu_wr && !is_upper ##1 load_strobe != 4'h0);
  COV_WORD_READ: cover property (
    rd_take && !is_upper && !is_compare ##1 rd_take && is_upper);
  COV_COMPARE_READ: cover property (rd_take && is_compare && is_upper);
  COV_REFUSED_READ: cover property (cpu_wr && cpu_rd);
  COV_HOLD_READ_BACK: cover property (cpu_wr && is_upper ##2 rd_take && is_upper);

endmodule // tbl_timer16_access

// >>> verification/tbl_timer_model.sv
`timescale 1ns/1ns
module tbl_timer_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Load request
  input  wire logic [3:0]  load_strobe,
  input  wire logic [15:0] load_data,
  // Live register contents
  output logic [3:0][15:0] word_q
);
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      word_q <= {4{16'h0000}};
    else
      for (int i = 0; i < 4; i++)
        if (load_strobe[i])
          word_q[i] <= load_data;
  end
endmodule // tbl_timer_model

// >>> verification/tb_timer16_byte_access_latch.sv
`timescale 1ns/1ns
module tb_timer16_byte_access_latch;
  logic             sys_clk = 1'h0;
  logic             rst_n = 1'h0;
  logic [2:0]       cpu_addr = 3'h0;
  logic             cpu_rd = 1'h0;
  logic             cpu_wr = 1'h0;
  logic [7:0]       cpu_wdata = 8'h00;
  logic [7:0]       cpu_rdata;
  logic             cpu_rvalid;
  logic [3:0]       load_strobe;
  logic [15:0]      load_data;
  logic [3:0][15:0] word_q;
  logic [7:0]       q;
  int               errors = 0;
  int               comparisons = 0;
  logic [15:0]      rows [4] = '{16'h01FF, 16'h8A5C, 16'h3C7E, 16'hF00D};

  tbl_timer16_access uut (.sys_clk(sys_clk), .rst_n(rst_n), .cpu_addr(cpu_addr),
    .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cpu_rvalid(cpu_rvalid), .timer_count_value(word_q[0]), .compare_value_a(word_q[1]),
    .compare_value_b(word_q[2]), .capture_value(word_q[3]),
    .load_strobe(load_strobe), .load_data(load_data));
  tbl_timer_model model (.sys_clk(sys_clk), .rst_n(rst_n), .load_strobe(load_strobe),
    .load_data(load_data), .word_q(word_q));

  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Bus tasks, no interrupts between bytes
  // ****************************************
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cpu_wr <= 1'h1;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge sys_clk);
    cpu_wr <= 1'h0;
    #1;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    cpu_rd <= 1'h1;
    cpu_addr <= a;
    @(posedge sys_clk);
    cpu_rd <= 1'h0;
    #1;
    chk("rvalid", 16'h0001, {15'h0000, cpu_rvalid});
    d = cpu_rdata;
  endtask

  task automatic final_report();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge sys_clk);
    #1;
    chk("reset outs", 16'h0000, {3'h0, cpu_rvalid, load_strobe, cpu_rdata});
    chk("reset load", 16'h0000, load_data);
    rst_n <= 1'h1;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 4; i++)
    begin
      wr({i[1:0], 1'h1}, rows[i][15:8]);
      wr({i[1:0], 1'h0}, rows[i][7:0]);
      chk("strobe", {12'h000, 4'(4'h1 << i)}, {12'h000, load_strobe});
      chk("load", rows[i], load_data);
      rd({i[1:0], 1'h0}, q);
      chk("rd lo", {8'h00, rows[i][7:0]}, {8'h00, q});
      rd({i[1:0], 1'h1}, q);
      chk("rd hi", {8'h00, rows[i][15:8]}, {8'h00, q});
    end
    rd(3'h0, q);
    rd(3'h2, q);
    rd(3'h3, q);
    chk("cmp hi", 16'h008A, {8'h00, q});
    rd(3'h1, q);
    chk("hold kept", 16'h0001, {8'h00, q});
    wr(3'h1, 8'h77);
    rd(3'h1, q);
    chk("hold rd", 16'h0077, {8'h00, q});
    wr(3'h6, 8'h22);
    chk("shared", 16'h7722, load_data);
    chk("cap strobe", 16'h0008, {12'h000, load_strobe});
    @(posedge sys_clk);
    cpu_rd <= 1'h1;
    cpu_wr <= 1'h1;
    cpu_addr <= 3'h1;
    cpu_wdata <= 8'h5A;
    @(posedge sys_clk);
    cpu_rd <= 1'h0;
    cpu_wr <= 1'h0;
    #1;
    chk("refused rd", 16'h0000, {15'h0000, cpu_rvalid});
    chk("strobe drop", 16'h0000, {12'h000, load_strobe});
    rd(3'h1, q);
    chk("write wins", 16'h005A, {8'h00, q});
    rst_n <= 1'h0;
    #1;
    chk("mid reset", 16'h0000, {3'h0, cpu_rvalid, load_strobe, cpu_rdata});
    chk("mid load", 16'h0000, load_data);
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge sys_clk);
    rd(3'h1, q);
    chk("hold reset", 16'h0000, {8'h00, q});
    final_report();
  end
endmodule // tb_timer16_byte_access_latch
